// [src/srr_responder.sv]
// Purpose: Answers function 03 reads of the status word over an RTU byte stream
// Assumes: Receiver gives bytes and a silent-line level on clk_in
// Notes:   Transmit side is a byte handshake to a sender
`timescale 1ns/1ps
`default_nettype none
module srr_responder #(
  parameter int SILENT_CYCLES = srr_pkg::SRR_SILENT_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       rx_valid_in,
  input  wire logic       rx_silent_in,
  output logic      [7:0] tx_data_out,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  output logic            busy_out,
  input  wire logic [3:0] axis_number_in,
  input  wire logic [3:0] io_pattern_in,
  input  wire logic [15:0] port_status_in,
  input  wire logic       emergency_stop_in,
  input  wire logic       safety_speed_in,
  input  wire logic       power_ready_in,
  input  wire logic       servo_on_in,
  input  wire logic       push_miss_in,
  input  wire logic       major_alarm_in,
  input  wire logic       minor_alarm_in,
  input  wire logic       absolute_error_in,
  input  wire logic       brake_release_in,
  input  wire logic       stop_active_in,
  input  wire logic       home_done_in,
  input  wire logic       position_done_in,
  input  wire logic       calibration_done_in,
  input  wire logic       calibration_status_in
);
  import srr_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ SRR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // State
  srr_state_t  state;
  srr_state_t  next_state;
  logic [7:0]  query [8];
  logic [3:0]  rx_count;
  logic        rx_overrun;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [2:0]  tx_idx;
  logic [15:0] resp_word;
  logic [31:0] gap_count;

  // ==========================================================
  // Live status words
  wire logic [15:0] status_word;
  wire logic [15:0] port_word;
  wire logic [15:0] live_word;
  assign status_word = {emergency_stop_in, safety_speed_in, power_ready_in, servo_on_in,
                        push_miss_in, major_alarm_in, minor_alarm_in, absolute_error_in,
                        brake_release_in, 1'b0, stop_active_in, home_done_in,
                        position_done_in, calibration_done_in, calibration_status_in,
                        1'b0};
  assign port_word = (io_pattern_in == SRR_PATTERN_SER) ? 16'h0000
                                                          : port_status_in;

  // ==========================================================
  // Query decode
  wire logic [7:0]  slave_addr;
  wire logic [15:0] start_addr;
  wire logic        addr_ok;
  wire logic        is_port;
  wire logic        query_ok;
  assign slave_addr = {4'h0, axis_number_in} + SRR_SLAVE_MIN;
  assign start_addr = {query[2], query[3]};
  assign is_port    = (start_addr == SRR_ADDR_OUTPRT);
  assign addr_ok    = (query[0] == slave_addr) && (slave_addr <= SRR_SLAVE_MAX);
  assign live_word  = is_port ? port_word : status_word;
  assign query_ok   = (rx_count == SRR_QUERY_LEN) && !rx_overrun && addr_ok
                      && (query[1] == SRR_FUNC_READ)
                      && ((start_addr == SRR_ADDR_STAT1) || is_port)
                      && ({query[4], query[5]} == SRR_REG_COUNT)
                      && (rx_crc == 16'h0000);

  // ==========================================================
  // Response bytes
  wire logic        tx_take;
  wire logic [15:0] next_tx_crc;
  wire logic [7:0]  next_tx_data;
  assign tx_take     = (state == SRR_SEND) && tx_ready_in;
  assign next_tx_crc = crc_step(tx_crc, tx_data_out);
  assign next_tx_data = (tx_idx == SRR_IDX_ADDR) ? SRR_FUNC_READ :
                        (tx_idx == SRR_IDX_FUNC) ? SRR_BYTE_COUNT :
                        (tx_idx == SRR_IDX_CNT)  ? resp_word[15:8] :
                        (tx_idx == SRR_IDX_HI)   ? resp_word[7:0] :
                        (tx_idx == SRR_IDX_LO)   ? next_tx_crc[7:0] :
                                                   tx_crc[15:8];
  assign tx_valid_out = (state == SRR_SEND);
  assign busy_out     = (state != SRR_COLLECT);
  wire logic gap_done;
  assign gap_done = (gap_count >= SILENT_CYCLES - 1);

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      SRR_COLLECT: begin
        if (rx_silent_in && rx_count != 4'h0) begin
          next_state = SRR_CHECK;
        end
      end
      SRR_CHECK: begin
        next_state = query_ok ? SRR_SEND : SRR_COLLECT;
      end
      SRR_SEND: begin
        if (tx_take && tx_idx == SRR_RESP_LAST) begin
          next_state = SRR_GAP;
        end
      end
      SRR_GAP: begin
        if (gap_done) begin
          next_state = SRR_COLLECT;
        end
      end
      default: next_state = SRR_COLLECT;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= SRR_COLLECT;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_count   <= 4'h0;
      rx_overrun <= 1'b0;
      rx_crc     <= SRR_CRC_INIT;
    end else if (ce_in) begin
      if (state != SRR_COLLECT) begin
        rx_count   <= 4'h0;
        rx_overrun <= 1'b0;
        rx_crc     <= SRR_CRC_INIT;
      end else if (rx_valid_in && rx_count == SRR_QUERY_LEN) begin
        rx_overrun <= 1'b1;
      end else if (rx_valid_in) begin
        rx_count <= rx_count + 4'h1;
        rx_crc   <= crc_step(rx_crc, rx_data_in);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && state == SRR_COLLECT && rx_valid_in && rx_count < SRR_QUERY_LEN) begin
      query[rx_count[2:0]] <= rx_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_data_out <= 8'h00;
      tx_idx      <= 3'h0;
      tx_crc      <= SRR_CRC_INIT;
      resp_word   <= 16'h0000;
    end else if (ce_in) begin
      if (state == SRR_CHECK) begin
        resp_word   <= live_word;
        tx_data_out <= slave_addr;
        tx_idx      <= 3'h0;
        tx_crc      <= SRR_CRC_INIT;
      end else if (tx_take) begin
        tx_data_out <= next_tx_data;
        tx_idx      <= tx_idx + 3'h1;
        if (tx_idx < SRR_RESP_CRCLO) begin
          tx_crc <= next_tx_crc;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_count <= 32'h0000_0000;
    end else if (ce_in) begin
      gap_count <= (state == SRR_GAP) ? gap_count + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_addr_byte: assert property (tx_valid_out && tx_idx == SRR_IDX_ADDR
    |-> tx_data_out == {4'h0, axis_number_in} + SRR_SLAVE_MIN) else $error("bad slave address");
  a_func_count: assert property (tx_valid_out && tx_idx == SRR_IDX_FUNC && ce_in && tx_ready_in
    |=> tx_data_out == SRR_BYTE_COUNT && tx_idx == SRR_IDX_CNT) else $error("bad byte count");
  a_resp_len: assert property (tx_valid_out |-> tx_idx <= SRR_RESP_LAST) else $error("response too long");
  a_crc_reject: assert property (ce_in && state == SRR_CHECK && rx_crc != 16'h0000
    |=> state == SRR_COLLECT) else $error("bad CRC answered");
  a_unused_zero: assert property (tx_valid_out && !is_port && tx_idx == SRR_IDX_LO
    |-> tx_data_out[6] == 1'b0 && tx_data_out[0] == 1'b0) else $error("unused bit set");
  a_pattern_zero: assert property (ce_in && state == SRR_CHECK && is_port
    && io_pattern_in == SRR_PATTERN_SER |=> resp_word == 16'h0000) else $error("port bits in pattern 6");
  a_fresh_word: assert property (ce_in && state == SRR_CHECK
    |=> resp_word == $past(live_word)) else $error("stale status");
  a_post_gap: assert property (ce_in && tx_take && tx_idx == SRR_RESP_LAST
    |=> state == SRR_GAP ##1 !tx_valid_out) else $error("no silence after response");
  a_pre_silence: assert property (ce_in && state == SRR_COLLECT && !rx_silent_in
    |=> !tx_valid_out) else $error("answer before silence");

  c_answer: cover property (tx_take && tx_idx == SRR_RESP_LAST);
  c_port_read: cover property (state == SRR_CHECK && query_ok && is_port);
  c_reject: cover property (state == SRR_CHECK && !query_ok);
endmodule
`default_nettype wire

// [src/srr_pkg.sv]
// Purpose: Constants for the status register read responder
// Assumes: Byte stream from a receiver on the same clock
// Notes:   Frame layout, field positions and timing counts
package srr_pkg;
  // ==========================================================
  // Frame fields
  localparam logic [7:0]  SRR_FUNC_READ   = 8'h03;
  localparam logic [7:0]  SRR_BYTE_COUNT  = 8'h02;
  localparam logic [15:0] SRR_ADDR_STAT1  = 16'h9005;
  localparam logic [15:0] SRR_ADDR_OUTPRT = 16'h9003;
  localparam logic [15:0] SRR_REG_COUNT   = 16'h0001;
  localparam logic [7:0]  SRR_SLAVE_MIN   = 8'h01;
  localparam logic [7:0]  SRR_SLAVE_MAX   = 8'h10;
  localparam logic [3:0]  SRR_QUERY_LEN   = 4'h8;
  localparam logic [2:0]  SRR_RESP_LAST   = 3'h6;
  localparam logic [2:0]  SRR_RESP_CRCLO  = 3'h5;
  localparam logic [3:0]  SRR_PATTERN_SER = 4'h6;
  // ==========================================================
  // Response byte positions
  localparam logic [2:0]  SRR_IDX_ADDR = 3'h0;
  localparam logic [2:0]  SRR_IDX_FUNC = 3'h1;
  localparam logic [2:0]  SRR_IDX_CNT  = 3'h2;
  localparam logic [2:0]  SRR_IDX_HI   = 3'h3;
  localparam logic [2:0]  SRR_IDX_LO   = 3'h4;
  // ==========================================================
  // CRC
  localparam logic [15:0] SRR_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] SRR_CRC_POLY = 16'hA001;
  // ==========================================================
  // Silent interval after a response
  localparam int          SRR_SILENT_US  = 1750;
  localparam int          SRR_CLK_MHZ    = 200;
  localparam int          SRR_SILENT_CYC = SRR_SILENT_US * SRR_CLK_MHZ;
  // ==========================================================
  // States
  typedef enum logic [3:0] {
    SRR_COLLECT = 4'b0001,
    SRR_CHECK   = 4'b0010,
    SRR_SEND    = 4'b0100,
    SRR_GAP     = 4'b1000
  } srr_state_t;
endpackage

// [tb/srr_master_model.sv]
// Purpose: Bus master model sending status read queries
// Assumes: Responder runs on the same clock
// Notes:   Slow mode toggles ready every cycle
`timescale 1ns/1ps
`default_nettype none
module srr_master_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic      [7:0] rx_data_out = 8'h00,
  output logic            rx_valid_out = 1'b0,
  output logic            rx_silent_out = 1'b1,
  output logic            tx_ready_out = 1'b0
);
  logic       slow = 1'b0;
  logic [7:0] resp[$];
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      resp.push_back(tx_data_in);
    end
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ {7'h00, bad});
    resp.delete();
    @(posedge clk_in);
    rx_silent_out <= 1'b0;
    foreach (q[i]) begin
      @(posedge clk_in);
      rx_data_out  <= q[i];
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
      rx_data_out  <= ~q[i];
      rx_valid_out <= 1'b0;
    end
    @(posedge clk_in);
    rx_silent_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the status read responder
// Assumes: Short silent count of 8 cycles
// Notes:   Master model drives queries and takes replies
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srr_pkg::*;
  localparam int GAP_CYC = 8;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] st     = 16'h0000;
  logic [15:0] port   = 16'h0000;
  logic [3:0]  axis   = 4'h0;
  logic [3:0]  pat    = 4'h0;
  logic [7:0]  tx_data, rx_data;
  logic        tx_valid, busy, rx_valid, rx_silent, tx_ready;
  int          n_mismatch = 0;
  int          num_checks = 0;
  srr_responder #(.SILENT_CYCLES(GAP_CYC)) srr_responder_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_silent_in(rx_silent), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .busy_out(busy),
    .axis_number_in(axis), .io_pattern_in(pat), .port_status_in(port),
    .emergency_stop_in(st[15]), .safety_speed_in(st[14]), .power_ready_in(st[13]),
    .servo_on_in(st[12]), .push_miss_in(st[11]), .major_alarm_in(st[10]),
    .minor_alarm_in(st[9]), .absolute_error_in(st[8]), .brake_release_in(st[7]),
    .stop_active_in(st[5]), .home_done_in(st[4]), .position_done_in(st[3]),
    .calibration_done_in(st[2]), .calibration_status_in(st[1]));
  srr_master_model master_inst (
    .clk_in(clk_in), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_silent_out(rx_silent),
    .tx_ready_out(tx_ready));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic query(input logic [7:0] slv, input logic [15:0] ra, input logic bad,
                       input logic reply, input logic [15:0] word);
    logic [7:0]  q[$];
    logic [15:0] c;
    int          n;
    int          g;
    g = 0;
    q = {slv, 8'h03, ra[15:8], ra[7:0], 8'h00, 8'h01};
    master_inst.send(q, bad);
    for (n = 0; n < 200; n++) begin
      @(posedge clk_in);
      #1;
      if (master_inst.resp.size() == 7 && busy === 1'b1) g++;
      if ((master_inst.resp.size() == 7 && busy === 1'b0) || (!reply && n == 40)) break;
    end
    if (n == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk_in);
    if (!reply) begin
      chk("reply size", 16'h0000, 16'(master_inst.resp.size()));
      return;
    end
    q = {slv, 8'h03, 8'h02, word[15:8], word[7:0]};
    c = master_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      chk("reply byte", {8'h00, q[i]}, {8'h00, master_inst.resp[i]});
    end
    chk("gap", 16'(GAP_CYC), 16'(g));
  endtask
  // ========================================
  // Scenarios
  task automatic t_sample();
    st <= 16'h3098;
    query(8'h01, SRR_ADDR_STAT1, 1'b0, 1'b1, 16'h3098);
    chk("known crc", 16'hADEE, {master_inst.resp[5], master_inst.resp[6]});
    $display("sample read done");
  endtask
  task automatic t_flags();
    axis <= 4'hF;
    st <= 16'hFFFF;
    master_inst.slow <= 1'b1;
    query(8'h10, SRR_ADDR_STAT1, 1'b0, 1'b1, 16'hFFBE);
    master_inst.slow <= 1'b0;
    axis <= 4'h0;
    $display("all flags read done");
  endtask
  task automatic t_refuse();
    query(8'h01, SRR_ADDR_STAT1, 1'b1, 1'b0, 16'h0000);
    query(8'h02, SRR_ADDR_STAT1, 1'b0, 1'b0, 16'h0000);
    st <= 16'h0022;
    query(8'h01, SRR_ADDR_STAT1, 1'b0, 1'b1, 16'h0022);
    $display("refusal and live read done");
  endtask
  task automatic t_port();
    port <= 16'h1234;
    pat <= SRR_PATTERN_SER;
    query(8'h01, SRR_ADDR_OUTPRT, 1'b0, 1'b1, 16'h0000);
    pat <= 4'h0;
    query(8'h01, SRR_ADDR_OUTPRT, 1'b0, 1'b1, 16'h1234);
    $display("port read done");
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_sample();
    t_flags();
    t_refuse();
    t_port();
    tally_and_finish();
  end
endmodule
`default_nettype wire
